// file: include/dout_pkg.sv
package dout_pkg;
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_POLARITY = 8'h04;
	localparam logic [7:0] ADDR_MAN_EN = 8'h08;
	localparam logic [7:0] ADDR_MAN_VAL = 8'h0c;
	localparam logic [7:0] ADDR_APPLIED = 8'h10;
	localparam logic [7:0] ADDR_ROUTE_EN = 8'h14;
	localparam logic [7:0] ADDR_LED = 8'h18;
	localparam logic [7:0] ADDR_ROUTE_BASE = 8'h40;
	localparam int FIRST_OUT_BIT = 16;
	localparam int BRAKE_BIT = 0;
	localparam int LED_GREEN_BIT = 0;
	localparam int LED_RED_BIT = 1;
	localparam int SEL_INV_BIT = 7;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [15:0] ROUTE_OFF = 16'h0fff;
	localparam logic [15:0] ROUTE_RESET = 16'h0fff;
	localparam logic [7:0] SRC_ONE = 8'h00;
	localparam logic [7:0] SRC_ZERO = 8'h01;
	localparam logic [7:0] SRC_ENC_FIRST = 8'h02;
	localparam logic [7:0] SRC_ENC_LAST = 8'h08;
	localparam logic [7:0] SRC_POS_FIRST = 8'h09;
	localparam logic [7:0] SRC_POS_LAST = 8'h0f;
	localparam logic [7:0] SRC_PWM = 8'h10;
	localparam logic [7:0] SRC_PWM_INV = 8'h11;
	localparam int CLK_HZ = 100_000_000;
	localparam int SWPWM_MAX_HZ = 2000;
	localparam int OUT_MAX_HZ = 500;
	localparam int SWPWM_MIN_HALF = (CLK_HZ + 2 * SWPWM_MAX_HZ - 1) / (2 * SWPWM_MAX_HZ);
	localparam int OUT_MIN_HALF = (CLK_HZ + 2 * OUT_MAX_HZ - 1) / (2 * OUT_MAX_HZ);
	localparam int LED_HALF = 25_000_000;
endpackage : dout_pkg

// file: verilog/digital_output_routing.sv
// Notes on behaviour
// - Output n follows control bit 15 plus n.
// - Low bits special; bit 0 drives brake.
// - Configuration bits act per matching output only.
// - Polarity bit set inverts the output.
// - Manual enable takes value from manual word.
// - Applied pattern readable in applied-state word.
// - LED bits enable green and red flashing.
// - Routing active only when enable equals 1.
// - Route entry: source high byte, bit low.
// - Entry bit 7 inverts the gating control bit.
// - Entry 0 soft PWM, entry k output k.
// - Entry value 0fff disables routing for output.
// - Source 00 constant one, 01 constant zero.
// - Sources 02..08 encoder pulses divided 1..64.
// - Sources 09..0f position pulses divided 1..64.
// - Source 10 PWM, 11 inverted PWM.
// - Divider 1 pulses per single count change.
// - Soft PWM to 2 kHz, others 500 Hz.
module digital_output_routing
	import dout_pkg::*;
#(
	parameter int NUM_OUT = 4,
	parameter int LED_HALF_CYC = LED_HALF,
	parameter int SWPWM_HALF_CYC = SWPWM_MIN_HALF,
	parameter int OUT_HALF_CYC = OUT_MIN_HALF
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [REG_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [31:0] ENCODER_COUNT,
	input wire logic [31:0] ACTUAL_POSITION,
	input wire logic PWM_IN,
	input wire logic FAULT,
	output logic [NUM_OUT-1:0] OUT_O,
	output logic [NUM_OUT-1:0] OUT_OE_N,
	output logic BRAKE_O,
	output logic BRAKE_OE_N,
	output logic SWPWM_O,
	output logic LED_GREEN,
	output logic LED_RED
);
	localparam int NUM_ROUTE = NUM_OUT + 1;
	localparam int IDX_W = $clog2(NUM_ROUTE + 1);

	logic [31:0] control;
	logic [31:0] polarity;
	logic [31:0] man_en;
	logic [31:0] man_val;
	logic [31:0] applied;
	logic [31:0] route_en;
	logic [31:0] led_ctrl;
	logic [15:0] route [NUM_ROUTE];
	logic [31:0] enc_prev;
	logic [31:0] pos_prev;
	logic [5:0] enc_div;
	logic [5:0] pos_div;
	logic enc_step;
	logic pos_step;
	logic routing_on;
	logic [NUM_ROUTE-1:0] route_gate;
	logic [NUM_ROUTE-1:0] route_sig;
	logic [NUM_ROUTE-1:0] route_raw;
	logic [NUM_ROUTE-1:0] route_lim;
	logic [31:0] next_rdata;
	logic [31:0] source_word;
	logic [31:0] next_applied;
	logic swpwm_direct;
	logic [24:0] led_cnt;
	logic led_phase;
	logic route_hit;
	logic [IDX_W-1:0] route_idx;

	// Only word-aligned addresses inside the table hit an entry; others are ignored.
	assign route_hit = (ADDR >= ADDR_ROUTE_BASE) && (ADDR[1:0] == 2'b00)
		&& ((ADDR - ADDR_ROUTE_BASE) < REG_ADDR_W'(4 * NUM_ROUTE));
	assign route_idx = IDX_W'((ADDR - ADDR_ROUTE_BASE) >> 2);

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			control <= RESET_WORD;
		end else if (WR && ADDR == ADDR_CONTROL) begin
			control <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			polarity <= RESET_WORD;
		end else if (WR && ADDR == ADDR_POLARITY) begin
			polarity <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			man_en <= RESET_WORD;
		end else if (WR && ADDR == ADDR_MAN_EN) begin
			man_en <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			man_val <= RESET_WORD;
		end else if (WR && ADDR == ADDR_MAN_VAL) begin
			man_val <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			route_en <= RESET_WORD;
		end else if (WR && ADDR == ADDR_ROUTE_EN) begin
			route_en <= WDATA;
		end
	end

	// Only the two LED enables are kept; the upper bits read back as zero.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			led_ctrl <= RESET_WORD;
		end else if (WR && ADDR == ADDR_LED) begin
			led_ctrl <= {30'h0, WDATA[1:0]};
		end
	end

	// Entries reset to the off code, so nothing is routed until software writes one.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			for (int i = 0; i < NUM_ROUTE; i++) begin
				route[i] <= ROUTE_RESET;
			end
		end else if (WR && route_hit) begin
			route[route_idx] <= WDATA[15:0];
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		if (RD && route_hit) begin
			next_rdata = {16'h0, route[route_idx]};
		end else if (RD) begin
			case (ADDR)
				ADDR_CONTROL: next_rdata = control;
				ADDR_POLARITY: next_rdata = polarity;
				ADDR_MAN_EN: next_rdata = man_en;
				ADDR_MAN_VAL: next_rdata = man_val;
				ADDR_APPLIED: next_rdata = applied;
				ADDR_ROUTE_EN: next_rdata = route_en;
				ADDR_LED: next_rdata = led_ctrl;
				default: next_rdata = 32'h0;
			endcase
		end
	end

	// Read data fall back to zero outside the answer cycle, so stale words never linger.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RDATA <= 32'h0;
		end else begin
			RDATA <= next_rdata;
		end
	end

	// A pulse is taken for each clock in which the count differs from last cycle.
	// Jumps of more than one count in a cycle still give a single pulse.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			enc_prev <= 32'h0;
			enc_step <= 1'b0;
		end else begin
			enc_prev <= ENCODER_COUNT;
			enc_step <= (ENCODER_COUNT != enc_prev);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pos_prev <= 32'h0;
			pos_step <= 1'b0;
		end else begin
			pos_prev <= ACTUAL_POSITION;
			pos_step <= (ACTUAL_POSITION != pos_prev);
		end
	end

	// Divider chains: bit k toggles every 2^k steps, so bit k is divide 2^(k+1) square wave.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			enc_div <= 6'h0;
		end else if (enc_step) begin
			enc_div <= enc_div + 6'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pos_div <= 6'h0;
		end else if (pos_step) begin
			pos_div <= pos_div + 6'h1;
		end
	end

	// Divide by one passes the single-cycle step pulse; larger dividers pass a counter bit.
	function automatic logic pick_div(input logic [5:0] div, input logic step,
		input logic [2:0] sel);
		logic r;
		r = 1'b0;
		case (sel)
			3'h0: r = step;
			3'h1: r = div[0];
			3'h2: r = div[1];
			3'h3: r = div[2];
			3'h4: r = div[3];
			3'h5: r = div[4];
			3'h6: r = div[5];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pick_div

	// Any value other than exactly one leaves every output on its direct control bit.
	assign routing_on = (route_en == 32'h1);

	// The gate index uses the low five bits only; bits 6 and 5 of an entry are ignored.
	always_comb begin
		for (int i = 0; i < NUM_ROUTE; i++) begin
			logic [7:0] sel;
			sel = route[i][7:0];
			route_gate[i] = control[sel[4:0]] ^ sel[SEL_INV_BIT];
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_ROUTE; i++) begin
			logic [7:0] src;
			src = route[i][15:8];
			route_sig[i] = 1'b0;
			if (src == SRC_ONE) begin
				route_sig[i] = 1'b1;
			end else if (src == SRC_ZERO) begin
				route_sig[i] = 1'b0;
			end else if (src >= SRC_ENC_FIRST && src <= SRC_ENC_LAST) begin
				route_sig[i] = pick_div(enc_div, enc_step, 3'(src - SRC_ENC_FIRST));
			end else if (src >= SRC_POS_FIRST && src <= SRC_POS_LAST) begin
				route_sig[i] = pick_div(pos_div, pos_step, 3'(src - SRC_POS_FIRST));
			end else if (src == SRC_PWM) begin
				route_sig[i] = PWM_IN;
			end else if (src == SRC_PWM_INV) begin
				route_sig[i] = ~PWM_IN;
			end
		end
	end

	assign route_raw = route_sig & route_gate;

	// Each routed line may change only after its minimum half period has passed.
	// Faster sources are thus slowed rather than passed at full rate.
	for (genvar g = 0; g < NUM_ROUTE; g++) begin : g_limit
		localparam int HALF = (g == 0) ? SWPWM_HALF_CYC : OUT_HALF_CYC;
		logic [31:0] hold;
		logic ready;
		assign ready = hold >= 32'(HALF - 1);
		always_ff @(posedge CLOCK) begin
			if (!RST_N) begin
				hold <= 32'h0;
			end else if (route_raw[g] != route_lim[g] && ready) begin
				hold <= 32'h0;
			end else if (!ready) begin
				hold <= hold + 32'h1;
			end
		end
		always_ff @(posedge CLOCK) begin
			if (!RST_N) begin
				route_lim[g] <= 1'b0;
			end else if (route_raw[g] != route_lim[g] && ready) begin
				route_lim[g] <= route_raw[g];
			end
		end
	end

	// Entry 0 feeds the soft PWM pin, entry k feeds output k.
	always_comb begin
		source_word = control;
		for (int i = 1; i < NUM_ROUTE; i++) begin
			if (routing_on && route[i] != ROUTE_OFF) begin
				source_word[FIRST_OUT_BIT + i - 1] = route_lim[i];
			end
		end
	end

	assign swpwm_direct = routing_on && route[0] != ROUTE_OFF && route_lim[0];

	// Manual override comes last, so it wins over both routing and polarity.
	always_comb begin
		next_applied = source_word ^ polarity;
		next_applied = (next_applied & ~man_en) | (man_val & man_en);
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			applied <= RESET_WORD;
		end else begin
			applied <= next_applied;
		end
	end

	// Open drain: the pin is pulled low when driven, released for a logical high.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			OUT_O <= '0;
			OUT_OE_N <= '1;
		end else begin
			OUT_O <= '0;
			OUT_OE_N <= next_applied[FIRST_OUT_BIT +: NUM_OUT];
		end
	end

	// The brake always follows bit 0 of the applied word; routing never reaches it.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			BRAKE_O <= 1'b0;
			BRAKE_OE_N <= 1'b1;
		end else begin
			BRAKE_O <= 1'b0;
			BRAKE_OE_N <= next_applied[BRAKE_BIT];
		end
	end

	// The soft PWM pin is push-pull and stays low while its entry or routing is off.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			SWPWM_O <= 1'b0;
		end else begin
			SWPWM_O <= swpwm_direct;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			led_cnt <= 25'h0;
			led_phase <= 1'b0;
		end else if (led_cnt >= 25'(LED_HALF_CYC - 1)) begin
			led_cnt <= 25'h0;
			led_phase <= ~led_phase;
		end else begin
			led_cnt <= led_cnt + 25'h1;
		end
	end

	// Both LEDs share one flash phase; a fault moves the flashing from green to red.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			LED_GREEN <= 1'b0;
		end else begin
			LED_GREEN <= led_ctrl[LED_GREEN_BIT] && !FAULT && led_phase;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			LED_RED <= 1'b0;
		end else begin
			LED_RED <= led_ctrl[LED_RED_BIT] && FAULT && led_phase;
		end
	end
endmodule : digital_output_routing

// file: sim/dout_sva.sv
module dout_sva
	import dout_pkg::*;
#(
	parameter int NUM_OUT = 4
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [REG_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [NUM_OUT-1:0] OUT_O,
	input wire logic [NUM_OUT-1:0] OUT_OE_N,
	input wire logic BRAKE_O,
	input wire logic BRAKE_OE_N,
	input wire logic SWPWM_O,
	input wire logic LED_GREEN,
	input wire logic LED_RED
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ctl, pol, men, mval, ren, want;
	logic [NUM_OUT-1:0] want_out;
	// Shadow copies of the control, polarity, manual and route-enable words let the output and brake pins be predicted from the bus while routing is off.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			{ctl, pol, men, mval, ren} <= '0;
		end else if (WR) begin
			case (ADDR)
				ADDR_CONTROL: ctl <= WDATA;
				ADDR_POLARITY: pol <= WDATA;
				ADDR_MAN_EN: men <= WDATA;
				ADDR_MAN_VAL: mval <= WDATA;
				ADDR_ROUTE_EN: ren <= WDATA;
				default: ;
			endcase
		end
	end
	assign want = ((ctl ^ pol) & ~men) | (mval & men);
	assign want_out = want[FIRST_OUT_BIT +: NUM_OUT];
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_pin_direct: assert property (
		$past(RST_N) && $past(ren) != 32'h1 |-> OUT_OE_N == $past(want_out)
	) else $error("output pins wrong");
	a_brake_pin: assert property (
		$past(RST_N) |-> BRAKE_OE_N == $past(want[BRAKE_BIT])
	) else $error("brake pin wrong");
	a_drain_low: assert property (OUT_O == '0 && !BRAKE_O) else $error("pin driven high");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("stray data");
	a_read_applied: assert property (
		$past(RST_N) && RD && ADDR == ADDR_APPLIED |=> RDATA[FIRST_OUT_BIT +: NUM_OUT]
		== $past(OUT_OE_N) && RDATA[BRAKE_BIT] == $past(BRAKE_OE_N)
	) else $error("applied word wrong");
	a_read_ctl: assert property (
		RD && ADDR == ADDR_CONTROL |=> RDATA == $past(ctl)
	) else $error("control readback wrong");
	a_swpwm_hold: assert property (
		$changed(SWPWM_O) |=> $stable(SWPWM_O)
	) else $error("soft pwm too fast");
	a_led_pair: assert property (!(LED_GREEN && LED_RED)) else $error("both leds on");
	c_routed: cover property (ren == 32'h1 && $changed(OUT_OE_N));
	c_red: cover property ($rose(LED_RED));
	c_swpwm: cover property ($rose(SWPWM_O));
endmodule : dout_sva

bind digital_output_routing dout_sva #(.NUM_OUT(NUM_OUT)) sva_u (.CLOCK(CLOCK), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OUT_O(OUT_O),
	.OUT_OE_N(OUT_OE_N), .BRAKE_O(BRAKE_O), .BRAKE_OE_N(BRAKE_OE_N), .SWPWM_O(SWPWM_O),
	.LED_GREEN(LED_GREEN), .LED_RED(LED_RED));

// file: sim/load_model.sv
module load_model #(
	parameter int N = 5
) (
	input wire logic [N-1:0] drive,
	input wire logic [N-1:0] oe_n,
	output logic [N-1:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Every load has a pull-up, so a released line reads high and never keeps its last level.
	always_comb begin
		for (int i = 0; i < N; i++) begin
			level[i] = oe_n[i] ? 1'b1 : drive[i];
		end
	end
endmodule : load_model

// file: sim/test_digital_output_routing.sv
module test_digital_output_routing;
	import dout_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 4;
	typedef struct {logic [31:0] ctl, pol, men, mval, exp;} row_t;
	logic clock = 0, rst_n = 0, wr = 0, rd = 0, pwm = 0, fault = 0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0, enc = '0, pos = '0, rdata;
	logic [N-1:0] out_o, out_oe_n;
	logic brake_o, brake_oe_n, swpwm, led_g, led_r;
	logic [N:0] lvl;
	logic [N+3:0] pins;
	int err_total = 0, cmp_count = 0;
	row_t rows [5] = '{
		'{32'h0001_0000, 32'h0, 32'h0, 32'h0, 32'h0001_0000},
		'{32'h000a_0001, 32'h0, 32'h0, 32'h0, 32'h000a_0001},
		'{32'h0003_0000, 32'h0001_0000, 32'h0, 32'h0, 32'h0002_0000},
		'{32'h0, 32'h000c_0000, 32'h0, 32'h0, 32'h000c_0000},
		'{32'h000f_0001, 32'h0, 32'h0005_0001, 32'h0004_0000, 32'h000e_0000}};
	logic [40:0] rt [7] = '{{16'h0005, 24'h20, 1'b1}, {16'h0085, 24'h20, 1'b0},
		{16'h0085, 24'h0, 1'b1}, {16'h0105, 24'h20, 1'b0}, {16'h1005, 24'h20, 1'b1},
		{16'h1105, 24'h20, 1'b0}, {16'h0fff, 24'h01_0000, 1'b1}};
	assign pins = {led_r, led_g, swpwm, lvl};
	digital_output_routing #(.NUM_OUT(N), .LED_HALF_CYC(4), .SWPWM_HALF_CYC(2),
		.OUT_HALF_CYC(4)) dut_u (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .ENCODER_COUNT(enc), .ACTUAL_POSITION(pos),
		.PWM_IN(pwm), .FAULT(fault), .OUT_O(out_o), .OUT_OE_N(out_oe_n), .BRAKE_O(brake_o),
		.BRAKE_OE_N(brake_oe_n), .SWPWM_O(swpwm), .LED_GREEN(led_g), .LED_RED(led_r));
	load_model #(.N(N + 1)) load_u (.drive({out_o, brake_o}), .oe_n({out_oe_n, brake_oe_n}),
		.level(lvl));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	// Routed lines pass a rate limiter, so their level is awaited rather than timed.
	task automatic wpin(input int i, input logic v, input string m);
		int n;
		n = 0;
		while (pins[i] !== v && n < 40) begin
			@(posedge clock);
			n++;
		end
		chk(32'(pins[i]), 32'(v), m);
		if (pins[i] !== v) close_out();
	endtask : wpin
	initial begin
		logic [31:0] d;
		logic p;
		repeat (16) @(posedge clock);
		chk(32'(lvl), 32'h1f, "reset pins");
		rst_n <= 1'b1;
		rreg(ADDR_ROUTE_BASE, d);
		chk(d, 32'h0fff, "reset route");
		rreg(8'h30, d);
		chk(d, 32'h0, "unmapped");
		wreg(ADDR_APPLIED, 32'hffff_ffff);
		rreg(ADDR_APPLIED, d);
		chk(d, 32'h0, "applied ro");
		$display("reset test done");
		foreach (rows[k]) begin
			wreg(ADDR_CONTROL, rows[k].ctl);
			wreg(ADDR_POLARITY, rows[k].pol);
			wreg(ADDR_MAN_EN, rows[k].men);
			wreg(ADDR_MAN_VAL, rows[k].mval);
			repeat (2) @(posedge clock);
			rreg(ADDR_APPLIED, d);
			chk(d, rows[k].exp, "applied");
			chk(32'(lvl), 32'({rows[k].exp[19:16], rows[k].exp[0]}), "pins");
			$display("row %0d done", k);
		end
		wreg(ADDR_MAN_EN, 32'h0);
		pwm <= 1'b1;
		wreg(ADDR_ROUTE_BASE + 8'h04, 32'h0005);
		wreg(ADDR_ROUTE_EN, 32'h2);
		wreg(ADDR_CONTROL, 32'h20);
		repeat (8) @(posedge clock);
		chk(32'(lvl[1]), 32'h0, "enable 2");
		wreg(ADDR_ROUTE_EN, 32'h1);
		foreach (rt[k]) begin
			wreg(ADDR_ROUTE_BASE + 8'h04, 32'(rt[k][40:25]));
			wreg(ADDR_CONTROL, 32'(rt[k][24:1]));
			wpin(1, rt[k][0], "route");
		end
		wreg(ADDR_ROUTE_BASE + 8'h04, 32'h0305);
		wreg(ADDR_CONTROL, 32'h20);
		repeat (8) @(posedge clock);
		p = lvl[1];
		enc <= enc + 32'h1;
		wpin(1, !p, "encoder");
		wreg(ADDR_ROUTE_BASE + 8'h04, 32'h0a05);
		repeat (8) @(posedge clock);
		p = lvl[1];
		pos <= pos + 32'h1;
		wpin(1, !p, "position");
		wreg(ADDR_ROUTE_BASE + 8'h04, 32'h0205);
		repeat (8) @(posedge clock);
		enc <= enc + 32'h1;
		wpin(1, 1'b1, "encoder div1");
		wreg(ADDR_ROUTE_BASE, 32'h0005);
		wpin(N + 1, 1'b1, "soft pwm");
		$display("routing test done");
		wreg(ADDR_LED, 32'h3);
		wpin(N + 2, 1'b1, "green");
		fault <= 1'b1;
		wpin(N + 3, 1'b1, "red");
		wreg(ADDR_LED, 32'h1);
		wpin(N + 3, 1'b0, "red off");
		repeat (12) @(posedge clock);
		chk(32'(pins[N+3:N+2]), 32'h0, "leds off");
		$display("led test done");
		close_out();
	end
endmodule : test_digital_output_routing
